// File: dual_pipe_hazard_and_branch_predict.sv
// Pair hazard resolution, branch prediction and misprediction recovery.
// Overview of operation
// - Move-type first op: one read, value delivered to both ops together.
// - Operand forwarding only when first op is a move leaving source intact.
// - Operand forwarding only when destination and source sizes match.
// - Computed result written to both destinations at once.
// - Result forwarding only when second op is a move, to register or memory.
// - Store then load of same location: stored value passed, load skipped.
// - Bypass only cacheable addresses; uncacheable loads really read.
// - A bypassed pair stalls the secondary pipe for exactly one clock.
// - Branch target table holds 512 entries, 4-way set associative.
// - A 1024-entry history table gives conditional taken history.
// - Unconditional branch hitting the target table redirects fetch.
// - Conditional branch hitting fetches at the history-predicted address.
// - Conditional branch missing the table predicts not taken.
// - Taken or not taken chosen by a four-state predictor.
// - Conditional branches go to the primary pipe only.
// - Resolve in operate stage if flags ready, else in store stage.
// - Correct prediction completes in one clock, no penalty.
// - Misprediction flushes and restarts fetch at the correct address.
// - Both predicted and alternate paths prefetched only for a conditional branch hitting the table.
// - Penalty is four cycles from operate stage, five from store stage.
// - Returns predicted from an eight-entry return stack; call pushes.
`timescale 1ns/1ps
module dual_pipe_hazard_and_branch_predict
  import pipe_ctl_pkg::*;
#(
  parameter int ADDR_W      = 32,
  parameter int DATA_W      = 32,
  parameter int BTT_ENTRIES = BTT_ENTRIES_DEF,
  parameter int BTT_WAYS    = BTT_WAYS_DEF,
  parameter int BHT_ENTRIES = BHT_ENTRIES_DEF,
  parameter int RS_DEPTH    = RSTACK_DEPTH_DEF
)
(
  // Clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_rst_b,
  // Instruction pair at the address stage
  input  wire logic              i_pair_valid,
  input  wire op_class_t         i_x_class,
  input  wire logic [2:0]        i_x_dst_reg,
  input  wire logic [1:0]        i_x_dst_size,
  input  wire logic              i_x_wr_mem,
  input  wire logic [ADDR_W-1:0] i_x_mem_addr,
  input  wire logic [DATA_W-1:0] i_x_data,
  input  wire logic              i_y_is_move,
  input  wire logic [2:0]        i_y_src_reg,
  input  wire logic [1:0]        i_y_src_size,
  input  wire logic              i_y_rd_mem,
  input  wire logic [ADDR_W-1:0] i_y_mem_addr,
  input  wire logic              i_y_cacheable,
  // Pair hazard answers
  output logic                   o_opnd_fwd,
  output logic                   o_res_fwd,
  output logic                   o_bypass,
  output logic                   o_y_stall,
  output logic                   o_y_mem_rd,
  output logic [DATA_W-1:0]      o_y_data,
  // Decode dispatch
  input  wire br_kind_t          i_dec_kind,
  output logic                   o_y_block,
  // Fetch prediction
  input  wire logic              i_fetch_valid,
  input  wire br_kind_t          i_fetch_kind,
  input  wire logic [ADDR_W-1:0] i_fetch_pc,
  input  wire logic [ADDR_W-1:0] i_fetch_seq_pc,
  output logic                   o_redirect,
  output logic [ADDR_W-1:0]      o_next_pc,
  output logic                   o_pred_taken,
  output logic                   o_alt_valid,
  output logic [ADDR_W-1:0]      o_alt_pc,
  // Branch resolution
  input  wire logic              i_res_valid,
  input  wire logic              i_res_cc_ready,
  input  wire logic              i_res_cond,
  input  wire logic              i_res_taken,
  input  wire logic [ADDR_W-1:0] i_res_pc,
  input  wire logic [ADDR_W-1:0] i_res_target,
  input  wire logic [ADDR_W-1:0] i_res_seq_pc,
  input  wire logic [ADDR_W-1:0] i_res_pred_pc,
  output logic                   o_br_done,
  output logic                   o_flush,
  output logic                   o_fetch_hold
);

  localparam int SETS  = BTT_ENTRIES / BTT_WAYS;
  localparam int SET_W = $clog2(SETS);
  localparam int WAY_W = $clog2(BTT_WAYS);
  localparam int TAG_W = ADDR_W - SET_W;
  localparam int BHT_W = $clog2(BHT_ENTRIES);
  localparam int RS_W  = $clog2(RS_DEPTH);

  // Branch target table and history storage.
  logic              btt_vld_q [SETS][BTT_WAYS];
  logic [TAG_W-1:0]  btt_tag_q [SETS][BTT_WAYS];
  logic [ADDR_W-1:0] btt_tgt_q [SETS][BTT_WAYS];
  pred_t             bht_q     [BHT_ENTRIES];
  logic [WAY_W-1:0]  victim_q;
  logic [ADDR_W-1:0] rs_q      [RS_DEPTH];
  logic [RS_W-1:0]   rs_top_q;
  logic [RS_W:0]     rs_cnt_q;
  res_state_t        res_st_q;
  logic [PEN_W-1:0]  pen_q;

  function automatic logic [SET_W-1:0] set_of(input logic [ADDR_W-1:0] pc);
    set_of = pc[SET_W-1:0];
  endfunction

  function automatic logic [TAG_W-1:0] tag_of(input logic [ADDR_W-1:0] pc);
    tag_of = pc[ADDR_W-1:SET_W];
  endfunction

  function automatic logic [BHT_W-1:0] bht_of(input logic [ADDR_W-1:0] pc);
    bht_of = pc[BHT_W-1:0];
  endfunction

  // Returns {hit, way} for a pc in the target table.
  function automatic logic [WAY_W:0] btt_find(input logic [ADDR_W-1:0] pc);
    logic [WAY_W:0] r;
    r = '0;
    for (int w = 0; w < BTT_WAYS; w++)
    begin
      if (btt_vld_q[set_of(pc)][w] && btt_tag_q[set_of(pc)][w] == tag_of(pc))
      begin
        r = {1'b1, WAY_W'(w)};
      end
    end
    return r;
  endfunction

  // Pair hazard detection.
  logic raw_reg;
  logic opnd_d;
  logic res_d;
  logic byp_d;
  assign raw_reg = i_pair_valid && !i_x_wr_mem && !i_y_rd_mem
                   && i_x_dst_reg == i_y_src_reg;
  assign opnd_d  = raw_reg && i_x_class == OP_MOVE
                   && i_x_dst_size == i_y_src_size;
  assign res_d   = raw_reg && i_x_class == OP_COMPUTE
                   && i_y_is_move;
  assign byp_d   = i_pair_valid && i_x_wr_mem && i_y_rd_mem
                   && i_x_mem_addr == i_y_mem_addr
                   && i_y_cacheable;

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_opnd_fwd <= 1'b0;
      o_res_fwd  <= 1'b0;
      o_bypass   <= 1'b0;
      o_y_stall  <= 1'b0;
      o_y_mem_rd <= 1'b0;
      o_y_data   <= '0;
    end
    else
    begin
      o_opnd_fwd <= opnd_d;
      o_res_fwd  <= res_d;
      o_bypass   <= byp_d;
      o_y_stall  <= byp_d;
      o_y_mem_rd <= i_pair_valid && i_y_rd_mem && !byp_d;
      o_y_data   <= i_x_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_y_block <= 1'b0;
    else
      o_y_block <= i_dec_kind == BR_COND;
  end

  // Resolution: operate stage when flags are ready, else one stage later.
  logic              res_fire;
  logic              res_store;
  logic              res_mis;
  logic [ADDR_W-1:0] res_actual;
  assign res_store  = res_st_q == RES_WAIT_STORE;
  assign res_fire   = res_store || (i_res_valid && i_res_cc_ready
                      && !o_fetch_hold);
  assign res_actual = i_res_taken ? i_res_target : i_res_seq_pc;
  assign res_mis    = res_fire && res_actual != i_res_pred_pc;

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      res_st_q <= RES_IDLE;
    else
      unique case (res_st_q)
        RES_IDLE:
          if (i_res_valid && !i_res_cc_ready && !o_fetch_hold)
            res_st_q <= RES_WAIT_STORE;
        RES_WAIT_STORE:
          res_st_q <= RES_IDLE;
      endcase
  end

  // Fetch is held for the whole penalty after a flush.
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_flush      <= 1'b0;
      o_br_done    <= 1'b0;
      o_fetch_hold <= 1'b0;
      pen_q        <= '0;
    end
    else
    begin
      o_flush   <= res_mis;
      o_br_done <= res_fire && !res_mis;
      if (res_mis)
      begin
        o_fetch_hold <= 1'b1;
        pen_q <= (res_store ? PEN_STORE_CYC : PEN_OPERATE_CYC) - PEN_ONE;
      end
      else if (pen_q != '0)
        pen_q <= pen_q - PEN_ONE;
      else
        o_fetch_hold <= 1'b0;
    end
  end

  // Fetch-time lookup and next-address choice.
  logic [WAY_W:0]    f_find;
  logic [ADDR_W-1:0] f_tgt;
  pred_t             f_ctr;
  logic [ADDR_W-1:0] rs_top;
  assign f_find = btt_find(i_fetch_pc);
  assign f_tgt  = btt_tgt_q[set_of(i_fetch_pc)][f_find[WAY_W-1:0]];
  assign f_ctr  = bht_q[bht_of(i_fetch_pc)];
  assign rs_top = rs_q[rs_top_q];

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_redirect   <= 1'b0;
      o_next_pc    <= '0;
      o_pred_taken <= 1'b0;
      o_alt_valid  <= 1'b0;
      o_alt_pc     <= '0;
    end
    else if (res_mis)
    begin
      o_redirect   <= 1'b1;
      o_next_pc    <= res_actual;
      o_pred_taken <= 1'b0;
      o_alt_valid  <= 1'b0;
    end
    else
    begin
      o_redirect   <= 1'b0;
      o_pred_taken <= 1'b0;
      o_alt_valid  <= 1'b0;
      o_next_pc    <= i_fetch_seq_pc;
      if (i_fetch_valid)
        unique case (i_fetch_kind)
          BR_UNCOND, BR_CALL:
            if (f_find[WAY_W])
            begin
              o_redirect <= 1'b1;
              o_next_pc  <= f_tgt;
            end
          BR_COND:
            if (f_find[WAY_W])
            begin
              o_alt_valid <= 1'b1;
              if (f_ctr[1])
              begin
                o_redirect   <= 1'b1;
                o_pred_taken <= 1'b1;
                o_next_pc    <= f_tgt;
                o_alt_pc     <= i_fetch_seq_pc;
              end
              else
                o_alt_pc <= f_tgt;
            end
          BR_RET:
            if (rs_cnt_q != '0)
            begin
              o_redirect <= 1'b1;
              o_next_pc  <= rs_top;
            end
          default:
            o_redirect <= 1'b0;
        endcase
    end
  end

  // Return stack is circular, so a push when full drops the oldest entry.
  // It is not repaired on a flush; a stale return recovers by mispredict.
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      rs_top_q <= '0;
      rs_cnt_q <= '0;
    end
    else if (i_fetch_valid && !res_mis)
    begin
      if (i_fetch_kind == BR_CALL)
      begin
        rs_top_q <= rs_top_q + 1'b1;
        if (rs_cnt_q != (RS_W+1)'(RS_DEPTH))
          rs_cnt_q <= rs_cnt_q + 1'b1;
      end
      else if (i_fetch_kind == BR_RET && rs_cnt_q != '0)
      begin
        rs_top_q <= rs_top_q - 1'b1;
        rs_cnt_q <= rs_cnt_q - 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_fetch_valid && !res_mis && i_fetch_kind == BR_CALL)
      rs_q[rs_top_q + 1'b1] <= i_fetch_seq_pc;
  end

  // Table training at resolution.
  logic [WAY_W:0] u_find;
  logic [WAY_W-1:0] u_way;
  assign u_find = btt_find(i_res_pc);
  assign u_way  = u_find[WAY_W] ? u_find[WAY_W-1:0] : victim_q;

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      victim_q <= '0;
      for (int s = 0; s < SETS; s++)
        for (int w = 0; w < BTT_WAYS; w++)
          btt_vld_q[s][w] <= 1'b0;
      for (int i = 0; i < BHT_ENTRIES; i++)
        bht_q[i] <= PRED_RESET;
    end
    else if (res_fire)
    begin
      if (i_res_taken)
      begin
        btt_vld_q[set_of(i_res_pc)][u_way] <= 1'b1;
        if (!u_find[WAY_W])
          victim_q <= victim_q + 1'b1;
      end
      if (i_res_cond)
        unique case (bht_q[bht_of(i_res_pc)])
          PRED_STRONG_NT:
            bht_q[bht_of(i_res_pc)] <= i_res_taken ? PRED_WEAK_NT
                                                   : PRED_STRONG_NT;
          PRED_WEAK_NT:
            bht_q[bht_of(i_res_pc)] <= i_res_taken ? PRED_WEAK_T
                                                   : PRED_STRONG_NT;
          PRED_WEAK_T:
            bht_q[bht_of(i_res_pc)] <= i_res_taken ? PRED_STRONG_T
                                                   : PRED_WEAK_NT;
          PRED_STRONG_T:
            bht_q[bht_of(i_res_pc)] <= i_res_taken ? PRED_STRONG_T
                                                   : PRED_WEAK_T;
        endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (res_fire && i_res_taken)
    begin
      btt_tag_q[set_of(i_res_pc)][u_way] <= tag_of(i_res_pc);
      btt_tgt_q[set_of(i_res_pc)][u_way] <= i_res_target;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  sequence s_mis_op;
    res_st_q == RES_IDLE && i_res_valid && i_res_cc_ready
      && !o_fetch_hold && res_actual != i_res_pred_pc;
  endsequence
  sequence s_mis_st;
    res_st_q == RES_WAIT_STORE && res_actual != i_res_pred_pc;
  endsequence

  property p_opnd_fwd;
    opnd_d |=> o_opnd_fwd && o_y_data == $past(i_x_data);
  endproperty
  a_opnd_fwd: assert property (p_opnd_fwd)
    else $error("operand forward missed");
  property p_opnd_move;
    o_opnd_fwd |-> $past(i_x_class) == OP_MOVE;
  endproperty
  a_opnd_move: assert property (p_opnd_move)
    else $error("operand forward from non-move");
  property p_opnd_size;
    o_opnd_fwd |-> $past(i_x_dst_size) == $past(i_y_src_size);
  endproperty
  a_opnd_size: assert property (p_opnd_size)
    else $error("operand forward with size mismatch");
  property p_res_move;
    o_res_fwd |-> $past(i_y_is_move) && $past(i_x_class) == OP_COMPUTE;
  endproperty
  a_res_move: assert property (p_res_move)
    else $error("result forward to non-move");
  property p_uncache_read;
    i_pair_valid && i_y_rd_mem && !i_y_cacheable |=> o_y_mem_rd && !o_bypass;
  endproperty
  a_uncache_read: assert property (p_uncache_read)
    else $error("uncacheable load was bypassed");
  property p_stall_one;
    o_bypass |-> o_y_stall && !o_y_mem_rd;
  endproperty
  a_stall_one: assert property (p_stall_one)
    else $error("bypass without single stall");
  property p_cond_x;
    i_dec_kind == BR_COND |=> o_y_block;
  endproperty
  a_cond_x: assert property (p_cond_x)
    else $error("conditional branch allowed to secondary pipe");
  property p_pen_op;
    s_mis_op |=> o_flush ##0 o_fetch_hold [*4] ##1 !o_fetch_hold;
  endproperty
  a_pen_op: assert property (p_pen_op)
    else $error("operate-stage penalty not four cycles");
  property p_pen_st;
    s_mis_st |=> o_flush ##0 o_fetch_hold [*5] ##1 !o_fetch_hold;
  endproperty
  a_pen_st: assert property (p_pen_st)
    else $error("store-stage penalty not five cycles");
  property p_correct;
    res_fire && !res_mis && !o_fetch_hold |=> o_br_done && !o_fetch_hold;
  endproperty
  a_correct: assert property (p_correct)
    else $error("correct branch paid a penalty");
  property p_ret_empty;
    i_fetch_valid && i_fetch_kind == BR_RET && rs_cnt_q == '0 && !res_mis
      |=> !o_redirect && o_next_pc == $past(i_fetch_seq_pc);
  endproperty
  a_ret_empty: assert property (p_ret_empty)
    else $error("empty return stack still predicted");

endmodule

// File: pipe_ctl_pkg.sv
// Shared constants and types for the dual-pipe hazard and branch control.
package pipe_ctl_pkg;

  localparam int BTT_ENTRIES_DEF  = 512;
  localparam int BTT_WAYS_DEF     = 4;
  localparam int BHT_ENTRIES_DEF  = 1024;
  localparam int RSTACK_DEPTH_DEF = 8;
  localparam int PEN_W            = 3;

  // Misprediction penalty in cycles per resolving stage.
  localparam logic [PEN_W-1:0] PEN_OPERATE_CYC = 3'h4;
  localparam logic [PEN_W-1:0] PEN_STORE_CYC   = 3'h5;
  localparam logic [PEN_W-1:0] PEN_ONE         = 3'h1;

  typedef enum logic [2:0]
  {
    BR_NONE   = 3'b000,
    BR_UNCOND = 3'b001,
    BR_COND   = 3'b010,
    BR_CALL   = 3'b011,
    BR_RET    = 3'b100
  } br_kind_t;

  typedef enum logic [1:0]
  {
    OP_MOVE    = 2'b00,
    OP_COMPUTE = 2'b01,
    OP_OTHER   = 2'b10
  } op_class_t;

  typedef enum logic [1:0]
  {
    PRED_STRONG_NT = 2'b00,
    PRED_WEAK_NT   = 2'b01,
    PRED_WEAK_T    = 2'b10,
    PRED_STRONG_T  = 2'b11
  } pred_t;

  localparam pred_t PRED_RESET = PRED_WEAK_NT;

  typedef enum logic [0:0]
  {
    RES_IDLE       = 1'b0,
    RES_WAIT_STORE = 1'b1
  } res_state_t;

endpackage

// File: branch_outcome_model.sv
// Far-side model that presents branch outcomes to the resolution port.
`timescale 1ns/1ps
module branch_outcome_model
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  // Outcome request from the bench
  input  wire logic        i_go,
  input  wire logic        i_cc_ready,
  input  wire logic        i_cond,
  input  wire logic        i_taken,
  input  wire logic [31:0] i_pc,
  input  wire logic [31:0] i_target,
  input  wire logic [31:0] i_seq_pc,
  input  wire logic [31:0] i_pred_pc,
  // Outcome presented to the block
  output logic             o_valid,
  output logic             o_cc_ready,
  output logic             o_cond,
  output logic             o_taken,
  output logic [31:0]      o_pc,
  output logic [31:0]      o_target,
  output logic [31:0]      o_seq_pc,
  output logic [31:0]      o_pred_pc
);
  logic [1:0] hold_q;

  // Valid stands one cycle. A branch whose flags are late keeps its outcome
  // one edge longer; afterwards the fields turn over, so a stale outcome
  // can never pass for a live one.
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      hold_q <= 2'h0;
      {o_valid, o_cc_ready, o_cond, o_taken} <= 4'h0;
      {o_pc, o_target, o_seq_pc, o_pred_pc} <= '0;
    end
    else if (i_go)
    begin
      hold_q <= i_cc_ready ? 2'h1 : 2'h2;
      o_valid <= 1'b1;
      {o_cc_ready, o_cond, o_taken} <= {i_cc_ready, i_cond, i_taken};
      {o_pc, o_target} <= {i_pc, i_target};
      {o_seq_pc, o_pred_pc} <= {i_seq_pc, i_pred_pc};
    end
    else
    begin
      o_valid <= 1'b0;
      if (hold_q == 2'h1)
      begin
        {o_cc_ready, o_cond, o_taken} <= ~{o_cc_ready, o_cond, o_taken};
        {o_pc, o_target} <= ~{o_pc, o_target};
        {o_seq_pc, o_pred_pc} <= ~{o_seq_pc, o_pred_pc};
      end
      if (hold_q != 2'h0)
        hold_q <= hold_q - 2'h1;
    end
  end
endmodule

// File: testbench.sv
// Self-checking bench for pair hazards, prediction and the return stack.
`timescale 1ns/1ps
module testbench
  import pipe_ctl_pkg::*;
;
  localparam logic [31:0] UA = 32'h00001000;
  localparam logic [31:0] UT = 32'h00002000;
  localparam logic [31:0] BA = 32'h00001040;
  localparam logic [31:0] BT = 32'h00003000;
  localparam logic [31:0] XK = 32'hC3A50F1E;

  logic        i_clk, i_rst_b, i_pair_valid, i_x_wr_mem, i_y_is_move;
  logic        i_y_rd_mem, i_y_cacheable, i_fetch_valid;
  logic        i_res_valid, i_res_cc_ready, i_res_cond, i_res_taken;
  logic        o_opnd_fwd, o_res_fwd, o_bypass, o_y_stall, o_y_mem_rd;
  logic        o_y_block, o_redirect, o_pred_taken, o_alt_valid;
  logic        o_br_done, o_flush, o_fetch_hold, go, cc, cond, tkn;
  logic [1:0]  i_x_dst_size, i_y_src_size;
  logic [2:0]  i_x_dst_reg, i_y_src_reg;
  logic [31:0] i_x_mem_addr, i_x_data, i_y_mem_addr, o_y_data;
  logic [31:0] i_fetch_pc, i_fetch_seq_pc, o_next_pc, o_alt_pc;
  logic [31:0] i_res_pc, i_res_target, i_res_seq_pc, i_res_pred_pc;
  logic [31:0] r_pc, r_tgt, r_seq, r_pred;
  op_class_t   i_x_class;
  br_kind_t    i_dec_kind, i_fetch_kind;
  int          miscompares, compares;

  dual_pipe_hazard_and_branch_predict i_dual_pipe_hazard_and_branch_predict
  (
    .i_clk, .i_rst_b, .i_pair_valid, .i_x_class, .i_x_dst_reg,
    .i_x_dst_size, .i_x_wr_mem, .i_x_mem_addr, .i_x_data, .i_y_is_move,
    .i_y_src_reg, .i_y_src_size, .i_y_rd_mem, .i_y_mem_addr,
    .i_y_cacheable, .o_opnd_fwd, .o_res_fwd, .o_bypass, .o_y_stall,
    .o_y_mem_rd, .o_y_data, .i_dec_kind, .o_y_block, .i_fetch_valid,
    .i_fetch_kind, .i_fetch_pc, .i_fetch_seq_pc, .o_redirect, .o_next_pc,
    .o_pred_taken, .o_alt_valid, .o_alt_pc, .i_res_valid, .i_res_cc_ready,
    .i_res_cond, .i_res_taken, .i_res_pc, .i_res_target, .i_res_seq_pc,
    .i_res_pred_pc, .o_br_done, .o_flush, .o_fetch_hold
  );

  branch_outcome_model i_branch_outcome_model
  (
    .i_clk, .i_rst_b, .i_go(go), .i_cc_ready(cc), .i_cond(cond),
    .i_taken(tkn), .i_pc(r_pc), .i_target(r_tgt), .i_seq_pc(r_seq),
    .i_pred_pc(r_pred), .o_valid(i_res_valid), .o_cc_ready(i_res_cc_ready),
    .o_cond(i_res_cond), .o_taken(i_res_taken), .o_pc(i_res_pc),
    .o_target(i_res_target), .o_seq_pc(i_res_seq_pc),
    .o_pred_pc(i_res_pred_pc)
  );

  task automatic finish_test();
    if (miscompares == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Flag bits f are {x writes mem, y reads mem, y is move, y cacheable}.
  task automatic pair(input op_class_t c, input logic [1:0] dsz, ssz,
                      input logic [3:0] f, input logic [2:0] sreg,
                      input logic [31:0] ya, input logic [2:0] e);
    @(posedge i_clk);
    i_pair_valid <= 1'b1;
    i_x_class <= c;
    {i_x_dst_size, i_y_src_size, i_y_src_reg} <= {dsz, ssz, sreg};
    {i_x_wr_mem, i_y_rd_mem, i_y_is_move, i_y_cacheable} <= f;
    {i_y_mem_addr, i_x_data} <= {ya, ya ^ XK};
    @(posedge i_clk);
    i_pair_valid <= 1'b0;
    #1;
    check("opnd_fwd", o_opnd_fwd, e[2]);
    check("res_fwd", o_res_fwd, e[1]);
    check("bypass", o_bypass, e[0]);
    check("y_stall", o_y_stall, e[0]);
    check("y_mem_rd", o_y_mem_rd, f[2] & ~e[0]);
    check("y_data", o_y_data, ya ^ XK);
  endtask

  // Expected bits e are {redirect, predicted taken, alternate valid}.
  task automatic fetch(input br_kind_t k, input logic [31:0] pc,
                       input logic [2:0] e, input logic [31:0] en, ea);
    @(posedge i_clk);
    {i_fetch_valid, i_fetch_kind} <= {1'b1, k};
    {i_fetch_pc, i_fetch_seq_pc} <= {pc, pc + 32'h4};
    @(posedge i_clk);
    i_fetch_valid <= 1'b0;
    #1;
    check("redirect", o_redirect, e[2]);
    check("next_pc", o_next_pc, en);
    check("pred_taken", o_pred_taken, e[1]);
    check("alt_valid", o_alt_valid, e[0]);
    if (e[0])
      check("alt_pc", o_alt_pc, ea);
  endtask

  task automatic res(input logic c, cd, t, input logic [31:0] pc, tgt, pred,
                     input int pen);
    int n;
    @(posedge i_clk);
    {go, cc, cond, tkn} <= {1'b1, c, cd, t};
    {r_pc, r_tgt, r_seq, r_pred} <= {pc, tgt, pc + 32'h4, pred};
    @(posedge i_clk);
    go <= 1'b0;
    #1;
    n = 0;
    while (o_flush !== 1'b1 && o_br_done !== 1'b1 && n < 6)
    begin
      @(posedge i_clk);
      #1;
      n++;
    end
    check("res_latency", n, c ? 1 : 2);
    check("flush", o_flush, pen != 0);
    check("br_done", o_br_done, pen == 0);
    if (pen != 0)
    begin
      check("flush_redirect", o_redirect, 1'b1);
      check("flush_pc", o_next_pc, t ? tgt : pc + 32'h4);
    end
    n = 0;
    while (o_fetch_hold === 1'b1 && n < 8)
    begin
      @(posedge i_clk);
      #1;
      n++;
    end
    check("penalty", n, pen);
  endtask

  task automatic test_pairs();
    pair(OP_MOVE, 2'h2, 2'h2, 4'h1, 3'h2, 32'h00000200, 3'h4);
    pair(OP_MOVE, 2'h2, 2'h1, 4'h1, 3'h2, 32'h00000204, 3'h0);
    pair(OP_MOVE, 2'h2, 2'h2, 4'h9, 3'h2, 32'h00000208, 3'h0);
    pair(OP_OTHER, 2'h2, 2'h2, 4'h3, 3'h2, 32'h0000020C, 3'h0);
    pair(OP_COMPUTE, 2'h2, 2'h2, 4'h3, 3'h2, 32'h00000210, 3'h2);
    pair(OP_COMPUTE, 2'h2, 2'h2, 4'h1, 3'h2, 32'h00000214, 3'h0);
    pair(OP_COMPUTE, 2'h2, 2'h2, 4'hD, 3'h5, 32'h00000100, 3'h1);
    pair(OP_COMPUTE, 2'h2, 2'h2, 4'hC, 3'h5, 32'h00000100, 3'h0);
    pair(OP_COMPUTE, 2'h2, 2'h2, 4'hD, 3'h5, 32'h00000104, 3'h0);
  endtask

  task automatic test_dispatch();
    for (int n = 0; n < 5; n++)
    begin
      @(posedge i_clk);
      i_dec_kind <= br_kind_t'(n);
      @(posedge i_clk);
      #1;
      check("y_block", o_y_block, br_kind_t'(n) == BR_COND);
    end
  endtask

  task automatic test_uncond();
    fetch(BR_UNCOND, UA, 3'h0, UA + 32'h4, '0);
    res(1'b1, 1'b0, 1'b1, UA, UT, UA + 32'h4, 4);
    fetch(BR_UNCOND, UA, 3'h4, UT, '0);
  endtask

  task automatic test_cond();
    fetch(BR_COND, BA, 3'h0, BA + 32'h4, '0);
    res(1'b0, 1'b1, 1'b1, BA, BT, BA + 32'h4, 5);
    fetch(BR_COND, BA, 3'h7, BT, BA + 32'h4);
    res(1'b1, 1'b1, 1'b1, BA, BT, BT, 0);
    res(1'b1, 1'b1, 1'b0, BA, BT, BT, 4);
    fetch(BR_COND, BA, 3'h7, BT, BA + 32'h4);
    res(1'b1, 1'b1, 1'b0, BA, BT, BT, 4);
    fetch(BR_COND, BA, 3'h1, BA + 32'h4, BT);
  endtask

  // Nine calls into an eight-deep stack lose the oldest return address.
  task automatic test_rstack();
    logic [31:0] p;
    for (int n = 0; n < 9; n++)
    begin
      p = 32'h00005000 + 32'(n * 16);
      fetch(BR_CALL, p, 3'h0, p + 32'h4, '0);
    end
    for (int n = 8; n > 0; n--)
    begin
      p = 32'h00005004 + 32'(n * 16);
      fetch(BR_RET, 32'h00006000, 3'h4, p, '0);
    end
    fetch(BR_RET, 32'h00006000, 3'h0, 32'h00006004, '0);
  endtask

  initial
  begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  initial
  begin
    #100000;
    miscompares++;
    finish_test();
  end

  initial
  begin
    miscompares = 0;
    compares = 0;
    i_rst_b = 1'b0;
    {i_pair_valid, i_x_wr_mem, i_y_is_move, i_y_rd_mem} = 4'h0;
    {i_y_cacheable, i_fetch_valid, go, cc, cond, tkn} = 6'h00;
    {i_x_dst_size, i_y_src_size, i_y_src_reg} = 7'h00;
    i_x_dst_reg = 3'h2;
    i_x_mem_addr = 32'h00000100;
    {i_x_data, i_y_mem_addr, i_fetch_pc, i_fetch_seq_pc} = '0;
    {r_pc, r_tgt, r_seq, r_pred} = '0;
    i_x_class = OP_MOVE;
    i_dec_kind = BR_NONE;
    i_fetch_kind = BR_NONE;
    repeat (8) @(posedge i_clk);
    #1;
    check("flush_in_reset", o_flush, 1'b0);
    check("hold_in_reset", o_fetch_hold, 1'b0);
    @(posedge i_clk);
    i_rst_b <= 1'b1;
    test_pairs();
    test_dispatch();
    test_uncond();
    test_cond();
    test_rstack();
    finish_test();
  end
endmodule
